// >>> rtl/deint_tune_pkg.sv
// Constants, register map and carriers of the cadence and motion tuning bank.
// Assumes one clock domain and a word-addressed plain register port.
// What this block does
// - Kernel SAD below threshold raises lock count
// - Each frame keeps or loses lock itself
// - SAD scaled by history within bias limits
// - Sad_bit_filter zero bits are ignored
// - Larger motion shift lowers noise sensitivity
// - Film overlay paints film pixels green
// - Motion overlay shows motion as pink
// - Motion scaled by gain over 32
// - Smaller scaled motion means more weave
// - Caption ratio code n means 4 to n
package deint_tune_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [4:0] OFS_CAPTION_RATIO = 5'h14;
    localparam logic [4:0] OFS_SAD_THRESHOLD = 5'h15;
    localparam logic [4:0] OFS_BIAS_FLOOR = 5'h16;
    localparam logic [4:0] OFS_BIAS_CEILING = 5'h17;
    localparam logic [4:0] OFS_SAD_FILTER = 5'h18;
    localparam logic [4:0] OFS_NOISE_SHIFT = 5'h19;
    localparam logic [4:0] OFS_FILM_OVERLAY = 5'h1a;
    localparam logic [4:0] OFS_MOTION_OVERLAY = 5'h1b;
    localparam logic [4:0] OFS_MOTION_GAIN = 5'h1e;
    localparam logic [4:0] OFS_STATUS = 5'h1f;
    localparam logic [2:0] CAPTION_CODE_MAX = 3'h5;
    localparam logic [3:0] BIAS_UNITY = 4'h4;
    localparam int BIAS_FRAC = 2;
    localparam int GAIN_FRAC = 5;
    localparam int STATUS_LOCK_BIT = 0;
    localparam int STATUS_VOF_BIT = 1;
    typedef struct packed {
        logic [2:0] caption_ratio;
        logic [7:0] sad_threshold;
        logic [2:0] bias_floor;
        logic [2:0] bias_ceiling;
        logic [9:0] sad_filter;
        logic [3:0] noise_shift;
        logic film_overlay;
        logic motion_overlay;
        logic [7:0] motion_gain;
    } tune_s;
    localparam tune_s TUNE_RESET = '{
        caption_ratio: 3'h0, sad_threshold: 8'hc8, bias_floor: 3'h0, bias_ceiling: 3'h7,
        sad_filter: 10'h3ff, noise_shift: 4'h3, film_overlay: 1'b0, motion_overlay: 1'b0,
        motion_gain: 8'h7d};
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
    } pixel_s;
    localparam pixel_s GREEN_PIXEL = '{y: 8'h91, cb: 8'h36, cr: 8'h22};
    localparam logic [7:0] PINK_CB = 8'ha0;
    localparam logic [7:0] PINK_CR = 8'hc0;
endpackage : deint_tune_pkg

// >>> rtl/deint_tune.sv
// Tuning register bank with a one-stage per-pixel cadence and motion path.
// Assumes the video path gives field_start_i and per-pixel data on core_clk_i.
`timescale 1ns/1ps
`default_nettype none
module deint_tune #(
    parameter int LOCK_W = 4,
    parameter int FILM_LEVEL = 8,
    parameter int CNT_W = 24
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [deint_tune_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [deint_tune_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [deint_tune_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic field_start_i,
    input wire logic pix_valid_i,
    input wire logic [9:0] pix_sad_i,
    input wire logic [2:0] pix_history_i,
    input wire logic [LOCK_W-1:0] pix_lock_cnt_i,
    input wire logic pix_caption_i,
    input wire logic [7:0] pix_motion_i,
    input wire deint_tune_pkg::pixel_s pix_i,
    output logic pix_valid_o,
    output logic [LOCK_W-1:0] pix_lock_cnt_o,
    output logic pix_film_o,
    output logic [7:0] pix_blend_o,
    output deint_tune_pkg::pixel_s pix_o,
    output logic cadence_lock_phase_o,
    output logic film_with_overlaid_video_o
);
    import deint_tune_pkg::*;

    localparam logic [LOCK_W-1:0] LOCK_MAX = {LOCK_W{1'b1}};
    localparam logic [LOCK_W-1:0] FILM_LVL = LOCK_W'(FILM_LEVEL);

    initial begin
        if (LOCK_W < 2 || LOCK_W > 8 || FILM_LEVEL < 1 || FILM_LEVEL >= (1 << LOCK_W)) begin
            $error("deint_tune: lock width or film level out of range");
        end
        if (CNT_W < 8 || CNT_W > 32) begin
            $error("deint_tune: counter width out of range");
        end
    end

    function automatic logic [DATA_W-1:0] read_word(input tune_s t, input logic [ADDR_W-1:0] a,
                                                    input logic lk, input logic vf);
        logic [DATA_W-1:0] d;
        d = '0;
        case (a)
            OFS_CAPTION_RATIO: d[2:0] = t.caption_ratio;
            OFS_SAD_THRESHOLD: d[7:0] = t.sad_threshold;
            OFS_BIAS_FLOOR: d[2:0] = t.bias_floor;
            OFS_BIAS_CEILING: d[2:0] = t.bias_ceiling;
            OFS_SAD_FILTER: d[9:0] = t.sad_filter;
            OFS_NOISE_SHIFT: d[3:0] = t.noise_shift;
            OFS_FILM_OVERLAY: d[0] = t.film_overlay;
            OFS_MOTION_OVERLAY: d[0] = t.motion_overlay;
            OFS_MOTION_GAIN: d[7:0] = t.motion_gain;
            OFS_STATUS: begin
                d[STATUS_LOCK_BIT] = lk;
                d[STATUS_VOF_BIT] = vf;
            end
            default: d = '0;
        endcase
        return d;
    endfunction : read_word

    tune_s shadow;
    tune_s active;
    tune_s next_shadow;

    // Software writes land in a shadow copy; reserved words fall through
    always_comb begin
        next_shadow = shadow;
        if (reg_wr_i) begin
            case (reg_addr_i)
                OFS_CAPTION_RATIO: next_shadow.caption_ratio = reg_wdata_i[2:0];
                OFS_SAD_THRESHOLD: next_shadow.sad_threshold = reg_wdata_i[7:0];
                OFS_BIAS_FLOOR: next_shadow.bias_floor = reg_wdata_i[2:0];
                OFS_BIAS_CEILING: next_shadow.bias_ceiling = reg_wdata_i[2:0];
                OFS_SAD_FILTER: next_shadow.sad_filter = reg_wdata_i[9:0];
                OFS_NOISE_SHIFT: next_shadow.noise_shift = reg_wdata_i[3:0];
                OFS_FILM_OVERLAY: next_shadow.film_overlay = reg_wdata_i[0];
                OFS_MOTION_OVERLAY: next_shadow.motion_overlay = reg_wdata_i[0];
                OFS_MOTION_GAIN: next_shadow.motion_gain = reg_wdata_i[7:0];
                default: next_shadow = shadow;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shadow <= TUNE_RESET;
        end else if (ce_i) begin
            shadow <= next_shadow;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active <= TUNE_RESET;
        end else if (ce_i && field_start_i) begin
            active <= shadow;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ?
                read_word(shadow, reg_addr_i, cadence_lock_phase_o, film_with_overlaid_video_o) :
                '0;
        end
    end

    // The first pixel of a field already uses the new settings
    tune_s cfg;
    assign cfg = field_start_i ? shadow : active;

    logic [9:0] masked_sad;
    assign masked_sad = pix_sad_i & cfg.sad_filter;

    // bias held between floor and ceiling
    logic [2:0] bias;
    always_comb begin
        bias = pix_history_i;
        if (bias > cfg.bias_ceiling) begin
            bias = cfg.bias_ceiling;
        end
        if (bias < cfg.bias_floor) begin
            bias = cfg.bias_floor;
        end
    end

    // lower bias shrinks SAD toward film
    logic [13:0] sad_product;
    logic [11:0] scaled_sad;
    assign sad_product = 14'(masked_sad) * 14'(BIAS_UNITY + {1'b0, bias});
    assign scaled_sad = sad_product[13:BIAS_FRAC];

    // count up below threshold, else down
    logic below;
    logic [LOCK_W-1:0] next_lock;
    assign below = scaled_sad < {4'h0, cfg.sad_threshold};
    always_comb begin
        if (below) begin
            next_lock = (pix_lock_cnt_i == LOCK_MAX) ? LOCK_MAX : pix_lock_cnt_i + 1'b1;
        end else begin
            next_lock = (pix_lock_cnt_i == '0) ? '0 : pix_lock_cnt_i - 1'b1;
        end
    end
    logic film_n;
    assign film_n = next_lock >= FILM_LVL;

    // shift first, then gain over 32
    logic [7:0] shifted_motion;
    logic [15:0] motion_product;
    logic [10:0] gained;
    logic [7:0] next_blend;
    assign shifted_motion = pix_motion_i >> cfg.noise_shift;
    assign motion_product = 16'(shifted_motion) * 16'(cfg.motion_gain);
    assign gained = motion_product[15:GAIN_FRAC];
    assign next_blend = (gained > 11'h0ff) ? 8'hff : gained[7:0];

    pixel_s next_pix;
    always_comb begin
        next_pix = pix_i;
        if (cfg.film_overlay && film_n) begin
            next_pix = GREEN_PIXEL;
        end else if (cfg.motion_overlay) begin
            next_pix = '{y: next_blend, cb: PINK_CB, cr: PINK_CR};
        end
    end

    // blend weight, zero means pure weave
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pix_valid_o <= 1'b0;
            pix_lock_cnt_o <= '0;
            pix_film_o <= 1'b0;
            pix_blend_o <= '0;
            pix_o <= '0;
        end else if (ce_i) begin
            pix_valid_o <= pix_valid_i;
            if (pix_valid_i) begin
                pix_lock_cnt_o <= next_lock;
                pix_film_o <= film_n;
                pix_blend_o <= next_blend;
                pix_o <= next_pix;
            end
        end
    end

    // Field statistics; a pixel in the start cycle opens the new field
    logic [CNT_W-1:0] ref_total;
    logic [CNT_W-1:0] ref_film;
    logic [CNT_W-1:0] cap_film;
    logic [CNT_W-1:0] add_ref;
    logic [CNT_W-1:0] add_ref_film;
    logic [CNT_W-1:0] add_cap_film;
    assign add_ref = CNT_W'(pix_valid_i && !pix_caption_i);
    assign add_ref_film = CNT_W'(pix_valid_i && !pix_caption_i && film_n);
    assign add_cap_film = CNT_W'(pix_valid_i && pix_caption_i && film_n);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_total <= '0;
            ref_film <= '0;
            cap_film <= '0;
        end else if (ce_i) begin
            if (field_start_i) begin
                ref_total <= add_ref;
                ref_film <= add_ref_film;
                cap_film <= add_cap_film;
            end else begin
                // Counters saturate so a huge field cannot wrap the decision
                if (ref_total != '1) ref_total <= ref_total + add_ref;
                if (ref_film != '1) ref_film <= ref_film + add_ref_film;
                if (cap_film != '1) cap_film <= cap_film + add_cap_film;
            end
        end
    end

    // each field judged on its own counts
    logic locked_n;
    assign locked_n = ({1'b0, ref_film} << 1) > {1'b0, ref_total};

    // ratio code n needs reference above 4 to n
    logic [2:0] ratio_code;
    logic [CNT_W+9:0] cap_scaled;
    logic ratio_ok;
    assign ratio_code = (active.caption_ratio > CAPTION_CODE_MAX) ? CAPTION_CODE_MAX :
                        active.caption_ratio;
    assign cap_scaled = (CNT_W+10)'(cap_film) << {ratio_code, 1'b0};
    assign ratio_ok = (ratio_code == 3'h0) || ((CNT_W+10)'(ref_film) > cap_scaled);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cadence_lock_phase_o <= 1'b0;
            film_with_overlaid_video_o <= 1'b0;
        end else if (ce_i && field_start_i) begin
            cadence_lock_phase_o <= locked_n;
            film_with_overlaid_video_o <= locked_n && ratio_ok;
        end
    end

    default clocking cb_main @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_pix_below;
        ce_i && pix_valid_i && below && pix_lock_cnt_i != LOCK_MAX;
    endsequence
    sequence s_pix_above;
        ce_i && pix_valid_i && !below;
    endsequence

    property p_lock_up;
        s_pix_below |=> pix_lock_cnt_o == $past(pix_lock_cnt_i) + 1'b1;
    endproperty
    a_lock_up: assert property (p_lock_up) else $error("lock count not raised");

    property p_lock_down;
        s_pix_above |=> pix_lock_cnt_o <= $past(pix_lock_cnt_i);
    endproperty
    a_lock_down: assert property (p_lock_down) else $error("lock count rose");

    property p_bias_range;
        pix_valid_i && cfg.bias_floor < cfg.bias_ceiling |->
            bias >= cfg.bias_floor && bias <= cfg.bias_ceiling;
    endproperty
    a_bias_range: assert property (p_bias_range) else $error("bias outside limits");

    property p_mask_ignore;
        pix_valid_i && (pix_sad_i & ~cfg.sad_filter) != '0 |->
            scaled_sad <= 12'((14'(pix_sad_i & cfg.sad_filter) * 14'(11)) >> BIAS_FRAC);
    endproperty
    a_mask_ignore: assert property (p_mask_ignore) else $error("masked SAD bits used");

    property p_unity_gain;
        ce_i && pix_valid_i && cfg.motion_gain == 8'h20 |=>
            pix_blend_o == ($past(pix_motion_i) >> $past(cfg.noise_shift));
    endproperty
    a_unity_gain: assert property (p_unity_gain) else $error("gain 32 changed motion");

    property p_still_weave;
        ce_i && pix_valid_i && pix_motion_i == 8'h00 |=> pix_blend_o == 8'h00;
    endproperty
    a_still_weave: assert property (p_still_weave) else $error("still pixel not woven");

    property p_film_green;
        ce_i && pix_valid_i && cfg.film_overlay && film_n |=> pix_o == GREEN_PIXEL && pix_film_o;
    endproperty
    a_film_green: assert property (p_film_green) else $error("film pixel not green");

    property p_motion_pink;
        ce_i && pix_valid_i && cfg.motion_overlay && !(cfg.film_overlay && film_n) |=>
            pix_o.cb == PINK_CB && pix_o.y == pix_blend_o;
    endproperty
    a_motion_pink: assert property (p_motion_pink) else $error("motion not pink");

    property p_ratio_gate;
        ce_i && field_start_i && !ratio_ok |=> !film_with_overlaid_video_o;
    endproperty
    a_ratio_gate: assert property (p_ratio_gate) else $error("video over film too early");

    property p_frame_lock;
        ce_i && field_start_i ##1 (!field_start_i || !ce_i)[*2] |->
            cadence_lock_phase_o == $past(locked_n, 2) && $stable(cadence_lock_phase_o);
    endproperty
    a_frame_lock: assert property (p_frame_lock) else $error("lock not per field");

    property p_hold_active;
        !(ce_i && field_start_i) |=> active == $past(active);
    endproperty
    a_hold_active: assert property (p_hold_active) else $error("settings changed mid field");

    property p_shift_quiet;
        ce_i && pix_valid_i && pix_motion_i < (8'h01 << cfg.noise_shift) |=> pix_blend_o == 8'h00;
    endproperty
    a_shift_quiet: assert property (p_shift_quiet) else $error("noise below shift moved");

    property p_field_load;
        ce_i && field_start_i |=> active == $past(shadow);
    endproperty
    a_field_load: assert property (p_field_load) else $error("shadow not loaded");

    property p_code_zero;
        ce_i && field_start_i && ratio_code == 3'h0 |=>
            film_with_overlaid_video_o == cadence_lock_phase_o;
    endproperty
    a_code_zero: assert property (p_code_zero) else $error("code zero gated verdict");

    property p_lock_top;
        ce_i && pix_valid_i && below && pix_lock_cnt_i == LOCK_MAX |=> pix_lock_cnt_o == LOCK_MAX;
    endproperty
    a_lock_top: assert property (p_lock_top) else $error("lock count wrapped");

    property p_film_flag;
        ce_i && pix_valid_i |=> pix_film_o == (pix_lock_cnt_o >= FILM_LVL);
    endproperty
    a_film_flag: assert property (p_film_flag) else $error("film flag wrong");
endmodule : deint_tune
`default_nettype wire

// >>> bench/deint_tune_tb.sv
// Self-checking bench for the tuning register bank and its pixel path.
// Assumes deint_tune_pkg and deint_tune are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module deint_tune_tb;
    import deint_tune_pkg::*;
    localparam pixel_s PIX_IN = '{y: 8'h40, cb: 8'h50, cr: 8'h60};
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic field_start_i = 1'b0;
    logic pix_valid_i = 1'b0;
    logic [9:0] pix_sad_i = 10'h0;
    logic [2:0] pix_history_i = 3'h0;
    logic [3:0] pix_lock_cnt_i = 4'h0;
    logic pix_caption_i = 1'b0;
    logic [7:0] pix_motion_i = 8'h0;
    pixel_s pix_i = PIX_IN;
    logic pix_valid_o;
    logic [3:0] pix_lock_cnt_o;
    logic pix_film_o;
    logic [7:0] pix_blend_o;
    pixel_s pix_o;
    logic cadence_lock_phase_o;
    logic film_with_overlaid_video_o;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    // Model copies of shadow and active tuning; active follows field starts
    tune_s sh_t = TUNE_RESET;
    tune_s ac_t = TUNE_RESET;
    // Rows: address, power-on value, value written, value read back
    logic [31:0] rows [12][4] = '{
        '{32'h14, 32'h0, 32'hfffffff2, 32'h2}, '{32'h15, 32'hc8, 32'hffffff5a, 32'h5a},
        '{32'h16, 32'h0, 32'hfffffff3, 32'h3}, '{32'h17, 32'h7, 32'hfffffff4, 32'h4},
        '{32'h18, 32'h3ff, 32'hfffffff0, 32'h3f0}, '{32'h19, 32'h3, 32'hfffffff5, 32'h5},
        '{32'h1a, 32'h0, 32'hffffffff, 32'h1}, '{32'h1b, 32'h0, 32'hffffffff, 32'h1},
        '{32'h1e, 32'h7d, 32'hffffff20, 32'h20}, '{32'h1c, 32'h0, 32'hffffffff, 32'h0},
        '{32'h1d, 32'h0, 32'hffffffff, 32'h0}, '{32'h00, 32'h0, 32'hffffffff, 32'h0}};

    deint_tune DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .field_start_i(field_start_i),
        .pix_valid_i(pix_valid_i), .pix_sad_i(pix_sad_i), .pix_history_i(pix_history_i),
        .pix_lock_cnt_i(pix_lock_cnt_i), .pix_caption_i(pix_caption_i),
        .pix_motion_i(pix_motion_i), .pix_i(pix_i), .pix_valid_o(pix_valid_o),
        .pix_lock_cnt_o(pix_lock_cnt_o), .pix_film_o(pix_film_o), .pix_blend_o(pix_blend_o),
        .pix_o(pix_o), .cadence_lock_phase_o(cadence_lock_phase_o),
        .film_with_overlaid_video_o(film_with_overlaid_video_o));

    always #12.5 core_clk_i = ~core_clk_i;

    // Whole run is well under a thousand cycles; the ceiling leaves margin
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            end_of_test();
        end
    end

    task end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task chk_pix(input string n, input pixel_s e, input pixel_s g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_pix

    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        case (a)
            OFS_CAPTION_RATIO: sh_t.caption_ratio = d[2:0];
            OFS_SAD_THRESHOLD: sh_t.sad_threshold = d[7:0];
            OFS_BIAS_FLOOR: sh_t.bias_floor = d[2:0];
            OFS_BIAS_CEILING: sh_t.bias_ceiling = d[2:0];
            OFS_SAD_FILTER: sh_t.sad_filter = d[9:0];
            OFS_NOISE_SHIFT: sh_t.noise_shift = d[3:0];
            OFS_FILM_OVERLAY: sh_t.film_overlay = d[0];
            OFS_MOTION_OVERLAY: sh_t.motion_overlay = d[0];
            OFS_MOTION_GAIN: sh_t.motion_gain = d[7:0];
            default: ;
        endcase
    endtask : wr

    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk("reg_rdata_o", e, reg_rdata_o);
    endtask : rd

    task check_resets();
        for (int i = 0; i < 12; i++) begin
            rd(rows[i][0][4:0], rows[i][1]);
        end
        rd(OFS_STATUS, 32'h0);
    endtask : check_resets

    // One pixel; the expectation is built from the active tuning copy
    task pix(input logic fs, input logic [9:0] sad, input logic [2:0] h,
             input logic [3:0] lk, input logic cap, input logic [7:0] mot);
        logic [3:0] b;
        int s;
        logic [3:0] nl;
        int bl;
        pixel_s e;
        @(posedge core_clk_i);
        if (fs) ac_t = sh_t;
        field_start_i <= fs;
        pix_valid_i <= 1'b1;
        pix_sad_i <= sad;
        pix_history_i <= h;
        pix_lock_cnt_i <= lk;
        pix_caption_i <= cap;
        pix_motion_i <= mot;
        b = (h > ac_t.bias_ceiling) ? 4'(ac_t.bias_ceiling) : 4'(h);
        if (b < ac_t.bias_floor) b = 4'(ac_t.bias_floor);
        s = (int'(sad & ac_t.sad_filter) * (4 + int'(b))) >> 2;
        if (s < ac_t.sad_threshold) nl = (lk == 4'hf) ? lk : lk + 4'h1;
        else nl = (lk == 4'h0) ? lk : lk - 4'h1;
        bl = ((int'(mot) >> ac_t.noise_shift) * int'(ac_t.motion_gain)) >> 5;
        if (bl > 255) bl = 255;
        e = PIX_IN;
        if (ac_t.motion_overlay) e = '{y: bl[7:0], cb: PINK_CB, cr: PINK_CR};
        if (ac_t.film_overlay && nl >= 4'h8) e = GREEN_PIXEL;
        @(posedge core_clk_i);
        pix_valid_i <= 1'b0;
        field_start_i <= 1'b0;
        #1;
        chk("pix_valid_o", 32'h1, 32'(pix_valid_o));
        chk("pix_lock_cnt_o", 32'(nl), 32'(pix_lock_cnt_o));
        chk("pix_film_o", 32'(nl >= 4'h8), 32'(pix_film_o));
        chk("pix_blend_o", 32'(bl), 32'(pix_blend_o));
        chk_pix("pix_o", e, pix_o);
    endtask : pix

    task verdict(input logic lk, input logic vf);
        @(posedge core_clk_i);
        #1;
        chk("cadence_lock_phase_o", 32'(lk), 32'(cadence_lock_phase_o));
        chk("film_with_overlaid_video_o", 32'(vf), 32'(film_with_overlaid_video_o));
    endtask : verdict

    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        check_resets();
        $display("test power-on values done");
        for (int i = 0; i < 12; i++) wr(rows[i][0][4:0], rows[i][2]);
        for (int i = 0; i < 12; i++) begin
            rd(rows[i][0][4:0], rows[i][3]);
        end
        // A write while the clock enable is low must leave the register alone
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        reg_wr_i <= 1'b1;
        reg_addr_i <= OFS_MOTION_GAIN;
        reg_wdata_i <= 32'h11;
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        reg_wr_i <= 1'b0;
        rd(OFS_MOTION_GAIN, 32'h20);
        $display("test register access done");
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        sh_t = TUNE_RESET;
        ac_t = TUNE_RESET;
        check_resets();
        $display("test second reset done");
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd64);
        pix(0, 10'd200, 3'd0, 4'd8, 0, 8'd0);
        pix(0, 10'd199, 3'd0, 4'd15, 0, 8'd0);
        pix(0, 10'd300, 3'd0, 4'd0, 0, 8'd0);
        pix(0, 10'd100, 3'd7, 4'd5, 0, 8'd0);
        wr(OFS_BIAS_CEILING, 32'h3);
        pix(0, 10'd100, 3'd7, 4'd5, 0, 8'd0);
        pix(1, 10'd100, 3'd7, 4'd5, 0, 8'd0);
        wr(OFS_BIAS_FLOOR, 32'h2);
        pix(1, 10'd140, 3'd0, 4'd5, 0, 8'd0);
        wr(OFS_BIAS_FLOOR, 32'h0);
        wr(OFS_SAD_FILTER, 32'h3f0);
        pix(1, 10'd207, 3'd0, 4'd5, 0, 8'd0);
        $display("test lock count done");
        wr(OFS_NOISE_SHIFT, 32'h0);
        wr(OFS_MOTION_GAIN, 32'd32);
        pix(1, 10'd100, 3'd0, 4'd5, 0, 8'd77);
        wr(OFS_MOTION_GAIN, 32'd255);
        pix(1, 10'd100, 3'd0, 4'd5, 0, 8'd200);
        wr(OFS_MOTION_GAIN, 32'd1);
        pix(1, 10'd100, 3'd0, 4'd5, 0, 8'd200);
        wr(OFS_NOISE_SHIFT, 32'h7);
        wr(OFS_MOTION_GAIN, 32'd255);
        pix(1, 10'd100, 3'd0, 4'd5, 0, 8'd255);
        $display("test motion scaling done");
        wr(OFS_FILM_OVERLAY, 32'h1);
        pix(1, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(0, 10'd300, 3'd0, 4'd7, 0, 8'd0);
        wr(OFS_MOTION_OVERLAY, 32'h1);
        pix(1, 10'd300, 3'd0, 4'd7, 0, 8'd255);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd255);
        $display("test overlays done");
        // Field of three film pixels, then one with a caption pixel, then a weak one
        wr(OFS_NOISE_SHIFT, 32'h3);
        pix(1, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        wr(OFS_CAPTION_RATIO, 32'h1);
        pix(1, 10'd300, 3'd0, 4'd7, 0, 8'd0);
        verdict(1, 1);
        rd(OFS_STATUS, 32'h3);
        wr(OFS_NOISE_SHIFT, 32'h5);
        rd(OFS_NOISE_SHIFT, 32'h5);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(0, 10'd100, 3'd0, 4'd7, 1, 8'd0);
        pix(1, 10'd300, 3'd0, 4'd7, 0, 8'd0);
        verdict(1, 0);
        rd(OFS_STATUS, 32'h1);
        pix(0, 10'd100, 3'd0, 4'd7, 0, 8'd0);
        pix(1, 10'd300, 3'd0, 4'd7, 0, 8'd0);
        verdict(0, 0);
        rd(OFS_STATUS, 32'h0);
        $display("test field verdicts done");
        end_of_test();
    end
endmodule : deint_tune_tb
`default_nettype wire
